// ### inc/hop_ctl_pkg.sv
package hop_ctl_pkg;
    // ************************************************************
    // Setup block map
    // ************************************************************
    localparam logic [7:0] ADDR_MODE     = 8'hF4;
    localparam logic [7:0] ADDR_IDLE0    = 8'hF5;
    localparam logic [7:0] ADDR_IDLE1    = 8'hF6;
    localparam logic [7:0] ADDR_IDLE2    = 8'hF7;
    localparam logic [7:0] ADDR_NOISE    = 8'hF8;
    localparam logic [7:0] ADDR_CRC_LO   = 8'hF9;
    localparam logic [7:0] ADDR_CRC_HI   = 8'hFA;
    localparam logic [7:0] ADDR_OFS_ONE  = 8'hF0;
    localparam logic [7:0] ADDR_OFS_TWO  = 8'hF1;
    localparam logic [7:0] ADDR_LAST     = 8'hFA;
    localparam int         MODE_MSB      = 7;
    localparam int         MODE_LSB      = 6;
    localparam int         LIMIT_MSB     = 7;
    localparam int         LIMIT_LSB     = 4;
    localparam int         THR_MSB       = 3;
    localparam int         THR_LSB       = 0;
    localparam logic [7:0] RST_MODE      = 8'hC0;
    localparam logic [7:0] RST_IDLE0     = 8'h01;
    localparam logic [7:0] RST_IDLE1     = 8'h06;
    localparam logic [7:0] RST_IDLE2     = 8'h3F;
    localparam logic [7:0] RST_NOISE     = 8'h32;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [1:0] HOP_OFF       = 2'h0;
    localparam logic [1:0] HOP_RECAL     = 2'h1;
    localparam logic [1:0] HOP_ADJUST    = 2'h2;
    localparam logic [1:0] HOP_SWEEP     = 2'h3;
    localparam logic [5:0] THR_BASE      = 6'h05;
    localparam logic [5:0] THR_STEP      = 6'h03;
    localparam logic [8:0] DELAY_ZERO    = 9'h100;
    localparam int         NUM_KEYS      = 24;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int         CLK_HZ        = 10_000_000;
    localparam int         MS_PER_SEC    = 1000;
    localparam int         CYC_PER_MS    = CLK_HZ / MS_PER_SEC;
    localparam int         PRD_MS        = 1000;
    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } setup_wr_t;
    typedef struct packed {
        logic              valid;
        logic [4:0]        key;
        logic signed [11:0] delta;
        logic              above_pos;
    } delta_in_t;
    typedef enum logic [1:0] {
        CRC_RUN   = 2'b01,
        CRC_CHECK = 2'b10
    } crc_state_t;
endpackage : hop_ctl_pkg

// ### rtl/burst_frequency_hop_control.sv
`timescale 1ns/1ps
// How it works
// - Mode 2 shifts every key reference at each hop by the offset of the new hop index, zero at index 0.
// - Modes 1 and 2 hold frequency and defer hops while calibrating.
// - Mode 3 sweeps idle delay between primary and secondary, one step per scan.
// - Mode 3 changes frequency without recalibration or reference offset.
// - Hop mode is two bits: off, recal, adjust, sweep; default sweep.
// - Primary idle delay sets the gap between burst pulses in mode 0 and at hop index 0.
// - Mode 0 bursts only at the primary idle delay, never hopping.
// - Modes 1 and 2 hop among three idle delays when noise persists.
// - Idle delay codes 1 to 255 are cycles; code 0 means 256.
// - Idle delays default to 1, 6 and 63 cycles.
// - Secondary unused in mode 0; tertiary and noise settings only in 1, 2.
// - A delta at or beyond the noise threshold bumps its polarity counter.
// - Noise threshold index 0 to 15 maps to 5 to 50 counts, default 2.
// - Separate positive and negative noise counters are kept.
// - A hop is considered only when both counters reach the limit.
// - Both noise counters clear at the end of every matrix scan.
// - Noise limit is four bits, default 3; values 0 to 2 reserved.
// - Device recomputes the checksum continually and flags any mismatch.
// - A key held above positive threshold for the delay is recalibrated.
// - Positive recalibration delay is fixed at 1000 ms.
// - Mode 1 recalibrates every key in the same cycle as each frequency change.
module burst_frequency_hop_control
    import hop_ctl_pkg::*;
#(
    parameter logic [15:0] CRC_POLY    = 16'h1021,
    parameter int          MS_CYCLES   = CYC_PER_MS
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire setup_wr_t  i_setup,
    input  wire logic [7:0] i_rd_addr,
    output logic [7:0]      o_rd_data,
    input  wire logic       i_scan_done,
    input  wire logic       i_calibrating,
    input  wire delta_in_t  i_delta,
    output logic [8:0]      o_idle_delay,
    output logic            o_freq_change,
    output logic            o_recal_all,
    output logic            o_ref_adjust,
    output logic [7:0]      o_ref_offset,
    output logic [NUM_KEYS-1:0] o_key_recal,
    output logic            o_crc_error
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [8:0] delay_cycles(input logic [7:0] code);
        delay_cycles = (code == RST_ZERO) ? DELAY_ZERO : {1'b0, code};
    endfunction : delay_cycles

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        crc_byte = r;
    endfunction : crc_byte

    // ************************************************************
    // Setup block
    // ************************************************************
    logic [7:0] mem_q [0:255];
    logic [7:0] rd_d, rd_q;

    always_comb begin
        rd_d = mem_q[i_rd_addr];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 256; i++) begin
                mem_q[i] <= RST_ZERO;
            end
            mem_q[ADDR_MODE]  <= RST_MODE;
            mem_q[ADDR_IDLE0] <= RST_IDLE0;
            mem_q[ADDR_IDLE1] <= RST_IDLE1;
            mem_q[ADDR_IDLE2] <= RST_IDLE2;
            mem_q[ADDR_NOISE] <= RST_NOISE;
            rd_q <= RST_ZERO;
        end else begin
            if (i_setup.we) begin
                mem_q[i_setup.addr] <= i_setup.data;
            end
            rd_q <= rd_d;
        end
    end

    logic [1:0] mode;
    logic [7:0] idle0, idle1, idle2;
    logic [5:0] noise_thr;
    logic [3:0] noise_lim;
    assign mode      = mem_q[ADDR_MODE][MODE_MSB:MODE_LSB];
    assign idle0     = mem_q[ADDR_IDLE0];
    assign idle1     = mem_q[ADDR_IDLE1];
    assign idle2     = mem_q[ADDR_IDLE2];
    assign noise_thr = THR_BASE + THR_STEP * mem_q[ADDR_NOISE][THR_MSB:THR_LSB];
    assign noise_lim = mem_q[ADDR_NOISE][LIMIT_MSB:LIMIT_LSB];
    assign o_rd_data = rd_q;

    // ************************************************************
    // Checksum engine
    // ************************************************************
    crc_state_t  crc_st_q, crc_st_d;
    logic [7:0]  crc_addr_q, crc_addr_d;
    logic [15:0] crc_q, crc_d;
    logic        crc_err_q, crc_err_d;

    always_comb begin
        crc_st_d   = crc_st_q;
        crc_addr_d = crc_addr_q;
        crc_d      = crc_q;
        crc_err_d  = crc_err_q;
        case (crc_st_q)
            CRC_RUN: begin
                crc_d      = crc_byte(crc_q, mem_q[crc_addr_q]);
                crc_addr_d = crc_addr_q + 8'h01;
                if (crc_addr_q == ADDR_CRC_LO - 8'h01) begin
                    crc_st_d = CRC_CHECK;
                end
            end
            CRC_CHECK: begin
                crc_err_d  = (crc_q != {mem_q[ADDR_CRC_HI], mem_q[ADDR_CRC_LO]});
                crc_d      = 16'h0000;
                crc_addr_d = 8'h00;
                crc_st_d   = CRC_RUN;
            end
            default: begin
                crc_st_d = CRC_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc_st_q   <= CRC_RUN;
            crc_addr_q <= 8'h00;
            crc_q      <= 16'h0000;
            crc_err_q  <= 1'b0;
        end else begin
            crc_st_q   <= crc_st_d;
            crc_addr_q <= crc_addr_d;
            crc_q      <= crc_d;
            crc_err_q  <= crc_err_d;
        end
    end
    assign o_crc_error = crc_err_q;

    // ************************************************************
    // Noise integrators and hop control
    // ************************************************************
    logic [3:0]  npos_q, npos_d, nneg_q, nneg_d;
    logic [1:0]  fidx_q, fidx_d;
    logic        pend_q, pend_d;
    logic        up_q, up_d;
    logic [8:0]  idle_q, idle_d;
    logic        chg_q, chg_d, rall_q, rall_d, radj_q, radj_d;
    logic [7:0]  rofs_q, rofs_d;
    logic [11:0] mag;
    logic        noisy, hop_mode, hit;

    always_comb begin
        npos_d   = npos_q;
        nneg_d   = nneg_q;
        fidx_d   = fidx_q;
        pend_d   = pend_q;
        up_d     = up_q;
        idle_d   = idle_q;
        chg_d    = 1'b0;
        rall_d   = 1'b0;
        radj_d   = 1'b0;
        rofs_d   = rofs_q;
        hop_mode = (mode == HOP_RECAL) || (mode == HOP_ADJUST);
        mag      = i_delta.delta[11] ? 12'(-i_delta.delta) : 12'(i_delta.delta);
        noisy    = i_delta.valid && hop_mode && (mag >= 12'(noise_thr));
        if (noisy && !i_delta.delta[11] && npos_q != 4'hF) begin
            npos_d = npos_q + 4'h1;
        end
        if (noisy && i_delta.delta[11] && nneg_q != 4'hF) begin
            nneg_d = nneg_q + 4'h1;
        end
        hit = (npos_q >= noise_lim) && (nneg_q >= noise_lim);
        if (i_scan_done) begin
            npos_d = 4'h0;
            nneg_d = 4'h0;
            if (hop_mode && hit) begin
                pend_d = 1'b1;
            end
        end
        case (mode)
            HOP_OFF: begin
                idle_d = delay_cycles(idle0);
                fidx_d = 2'h0;
                pend_d = 1'b0;
            end
            HOP_SWEEP: begin
                pend_d = 1'b0;
                if (idle_q < delay_cycles(idle0) || idle_q > delay_cycles(idle1)) begin
                    idle_d = delay_cycles(idle0);
                    up_d   = 1'b1;
                end else if (i_scan_done) begin
                    chg_d = 1'b1;
                    if (up_q && idle_q < delay_cycles(idle1)) begin
                        idle_d = idle_q + 9'h001;
                    end else if (!up_q && idle_q > delay_cycles(idle0)) begin
                        idle_d = idle_q - 9'h001;
                    end else begin
                        up_d   = !up_q;
                        idle_d = up_q ? idle_q - 9'h001 : idle_q + 9'h001;
                    end
                end
            end
            default: begin
                if (pend_q && !i_calibrating) begin
                    pend_d = i_scan_done && hit;
                    chg_d  = 1'b1;
                    fidx_d = (fidx_q == 2'h2) ? 2'h0 : fidx_q + 2'h1;
                    rall_d = (mode == HOP_RECAL);
                    radj_d = (mode == HOP_ADJUST);
                    rofs_d = (fidx_q == 2'h0) ? mem_q[ADDR_OFS_ONE]
                           : (fidx_q == 2'h1) ? mem_q[ADDR_OFS_TWO] : RST_ZERO;
                end
                case (fidx_d)
                    2'h1:    idle_d = delay_cycles(idle1);
                    2'h2:    idle_d = delay_cycles(idle2);
                    default: idle_d = delay_cycles(idle0);
                endcase
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            npos_q <= 4'h0;
            nneg_q <= 4'h0;
            fidx_q <= 2'h0;
            pend_q <= 1'b0;
            up_q   <= 1'b1;
            idle_q <= {1'b0, RST_IDLE0};
            chg_q  <= 1'b0;
            rall_q <= 1'b0;
            radj_q <= 1'b0;
            rofs_q <= RST_ZERO;
        end else begin
            npos_q <= npos_d;
            nneg_q <= nneg_d;
            fidx_q <= fidx_d;
            pend_q <= pend_d;
            up_q   <= up_d;
            idle_q <= idle_d;
            chg_q  <= chg_d;
            rall_q <= rall_d;
            radj_q <= radj_d;
            rofs_q <= rofs_d;
        end
    end
    assign o_idle_delay  = idle_q;
    assign o_freq_change = chg_q;
    assign o_recal_all   = rall_q;
    assign o_ref_adjust  = radj_q;
    assign o_ref_offset  = rofs_q;

    // ************************************************************
    // Positive recalibration timers
    // ************************************************************
    logic [23:0]         ms_cnt_q, ms_cnt_d;
    logic                ms_tick;
    logic [NUM_KEYS-1:0] above_q, above_d, krec_q, krec_d;
    logic [9:0]          ktim_q [0:NUM_KEYS-1];
    logic [9:0]          ktim_d [0:NUM_KEYS-1];

    always_comb begin
        ms_tick  = (ms_cnt_q == 24'(MS_CYCLES - 1));
        ms_cnt_d = ms_tick ? 24'h000000 : ms_cnt_q + 24'h000001;
        above_d  = above_q;
        krec_d   = '0;
        for (int k = 0; k < NUM_KEYS; k++) begin
            ktim_d[k] = ktim_q[k];
            if (!above_q[k]) begin
                ktim_d[k] = 10'h000;
            end else if (ms_tick) begin
                if (ktim_q[k] == 10'(PRD_MS - 1)) begin
                    krec_d[k]  = 1'b1;
                    ktim_d[k]  = 10'h000;
                    above_d[k] = 1'b0;
                end else begin
                    ktim_d[k] = ktim_q[k] + 10'h001;
                end
            end
        end
        if (i_delta.valid && i_delta.key < 5'(NUM_KEYS)) begin
            above_d[i_delta.key] = i_delta.above_pos;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ms_cnt_q <= 24'h000000;
            above_q  <= '0;
            krec_q   <= '0;
            for (int k = 0; k < NUM_KEYS; k++) begin
                ktim_q[k] <= 10'h000;
            end
        end else begin
            ms_cnt_q <= ms_cnt_d;
            above_q  <= above_d;
            krec_q   <= krec_d;
            for (int k = 0; k < NUM_KEYS; k++) begin
                ktim_q[k] <= ktim_d[k];
            end
        end
    end
    assign o_key_recal = krec_q;
endmodule : burst_frequency_hop_control

// ### bench/hop_ctl_chk.sv
`timescale 1ns/1ps
module hop_ctl_chk
    import hop_ctl_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire setup_wr_t  i_setup,
    input  wire logic       i_scan_done,
    input  wire logic       i_calibrating,
    input  wire logic [8:0] o_idle_delay,
    input  wire logic       o_freq_change,
    input  wire logic       o_recal_all,
    input  wire logic       o_ref_adjust
);
    // ********
    // Shadow of mode and primary delay
    // ********
    logic [1:0] mode_q, mode_d, quiet_q, quiet_d;
    logic [7:0] prim_q, prim_d;
    logic       calm;
    logic [8:0] prim_cyc;
    always_comb begin
        mode_d  = mode_q;
        prim_d  = prim_q;
        quiet_d = (quiet_q == 2'h3) ? quiet_q : quiet_q + 2'h1;
        if (i_setup.we) begin
            quiet_d = 2'h0;
            if (i_setup.addr == ADDR_MODE) mode_d = i_setup.data[MODE_MSB:MODE_LSB];
            if (i_setup.addr == ADDR_IDLE0) prim_d = i_setup.data;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_q  <= RST_MODE[MODE_MSB:MODE_LSB];
            prim_q  <= RST_IDLE0;
            quiet_q <= 2'h3;
        end else begin
            mode_q  <= mode_d;
            prim_q  <= prim_d;
            quiet_q <= quiet_d;
        end
    end
    assign calm     = (quiet_q == 2'h3);
    assign prim_cyc = (prim_q == 8'h00) ? DELAY_ZERO : {1'b0, prim_q};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_hop_mode;
        calm && (mode_q == HOP_RECAL || mode_q == HOP_ADJUST);
    endsequence
    sequence s_sweep_scan;
        calm && mode_q == HOP_SWEEP && i_scan_done;
    endsequence
    property p_sweep_step;
        s_sweep_scan |=> o_freq_change;
    endproperty
    property p_sweep_refs;
        calm && mode_q == HOP_SWEEP |-> !o_recal_all && !o_ref_adjust;
    endproperty
    property p_off_quiet;
        calm && mode_q == HOP_OFF |-> !o_freq_change;
    endproperty
    property p_off_primary;
        calm && mode_q == HOP_OFF |-> o_idle_delay == prim_cyc;
    endproperty
    property p_recal_pair;
        calm && mode_q == HOP_RECAL |-> o_recal_all == o_freq_change && !o_ref_adjust;
    endproperty
    property p_adjust_pair;
        calm && mode_q == HOP_ADJUST |-> o_ref_adjust == o_freq_change && !o_recal_all;
    endproperty
    property p_cal_hold;
        s_hop_mode ##0 i_calibrating [*2] |=> !o_freq_change;
    endproperty
    property p_idle_range;
        o_idle_delay != 9'h000 && o_idle_delay <= DELAY_ZERO;
    endproperty
    a_sweep_step: assert property (p_sweep_step) else $error("sweep scan without step");
    a_sweep_refs: assert property (p_sweep_refs) else $error("sweep touched refs");
    a_off_quiet: assert property (p_off_quiet) else $error("hop while off");
    a_off_primary: assert property (p_off_primary) else $error("idle not primary");
    a_recal_pair: assert property (p_recal_pair) else $error("recal pulse mismatch");
    a_adjust_pair: assert property (p_adjust_pair) else $error("adjust pulse mismatch");
    a_cal_hold: assert property (p_cal_hold) else $error("hop while calibrating");
    a_idle_range: assert property (p_idle_range) else $error("idle out of range");
endmodule : hop_ctl_chk

bind burst_frequency_hop_control hop_ctl_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_setup(i_setup), .i_scan_done(i_scan_done), .i_calibrating(i_calibrating),
    .o_idle_delay(o_idle_delay), .o_freq_change(o_freq_change),
    .o_recal_all(o_recal_all), .o_ref_adjust(o_ref_adjust));

// ### bench/setup_host.sv
`timescale 1ns/1ps
module setup_host
    import hop_ctl_pkg::*;
#(
    parameter logic [15:0] CRC_POLY = 16'h1021
) (
    input  wire logic i_clk,
    output setup_wr_t o_setup
);
    // ********
    // Host image of the setup block
    // ********
    logic [7:0] img [256];
    initial begin
        o_setup = '0;
        foreach (img[a]) img[a] = RST_ZERO;
        img[ADDR_MODE]  = RST_MODE;
        img[ADDR_IDLE0] = RST_IDLE0;
        img[ADDR_IDLE1] = RST_IDLE1;
        img[ADDR_IDLE2] = RST_IDLE2;
        img[ADDR_NOISE] = RST_NOISE;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_setup = '{we: 1'b1, addr: a, data: d};
        img[a]  = d;
        @(posedge i_clk);
        #1;
        o_setup.we = 1'b0;
    endtask : wr
    task automatic seal(input logic bad);
        logic [15:0] c;
        c = 16'h0000;
        for (int a = 0; a <= 248; a++) begin
            c = c ^ {img[a], 8'h00};
            repeat (8) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        wr(ADDR_CRC_LO, c[7:0]);
        wr(ADDR_CRC_HI, c[15:8] ^ {7'h00, bad});
    endtask : seal
endmodule : setup_host

// ### bench/burst_frequency_hop_control_tb.sv
`timescale 1ns/1ps
module burst_frequency_hop_control_tb;
    import hop_ctl_pkg::*;
    localparam int MS = 2;
    logic clk, rst_n, scan_done, calibrating, fchg, recal, radj, crc_err;
    logic [7:0] rd_addr, rd_data, rofs;
    logic [8:0] idle;
    logic [23:0] krecal;
    setup_wr_t setup;
    delta_in_t delta;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    setup_host #(.CRC_POLY(16'h1021)) host (.i_clk(clk), .o_setup(setup));
    burst_frequency_hop_control #(.CRC_POLY(16'h1021), .MS_CYCLES(MS)) dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_setup(setup), .i_rd_addr(rd_addr),
        .o_rd_data(rd_data), .i_scan_done(scan_done), .i_calibrating(calibrating),
        .i_delta(delta), .o_idle_delay(idle), .o_freq_change(fchg), .o_recal_all(recal),
        .o_ref_adjust(radj), .o_ref_offset(rofs), .o_key_recal(krecal), .o_crc_error(crc_err));
    // ********
    // Clock, timeout and tasks
    // ********
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        rd_addr = a;
        @(posedge clk);
        #1;
        chk(rd_data, exp);
    endtask : rd
    task automatic scan();
        @(posedge clk);
        #1;
        scan_done = 1'b1;
        @(posedge clk);
        #1;
        scan_done = 1'b0;
    endtask : scan
    task automatic noise(input int n, input logic signed [11:0] d);
        repeat (n) begin
            @(posedge clk);
            #1;
            delta = '{1'b1, 5'h00, d, 1'b0};
        end
        @(posedge clk);
        #1;
        delta.valid = 1'b0;
    endtask : noise
    task automatic no_hop(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk(fchg, 24'h0);
        end
    endtask : no_hop
    task automatic wait_hop(input logic [8:0] ei, input logic [1:0] ek, input logic [7:0] eo);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            if (fchg === 1'b1) break;
        end
        chk(fchg, 24'h1);
        chk({radj, recal}, ek);
        chk(idle, ei);
        if (ek[1]) chk(rofs, eo);
    endtask : wait_hop
    // ********
    // Main sequence
    // ********
    initial begin
        logic [8:0] e;
        logic       up;
        logic [7:0] dflt [5];
        int         cnt;
        dflt = '{8'hC0, 8'h01, 8'h06, 8'h3F, 8'h32};
        rst_n = 1'b0;
        scan_done = 1'b0;
        calibrating = 1'b0;
        rd_addr = 8'h00;
        delta = '0;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(idle, 24'h1);
        for (int i = 0; i < 5; i++) rd(8'hF4 + 8'(i), dflt[i]);
        e = 9'h001;
        up = 1'b1;
        for (int i = 0; i < 12; i++) begin
            e = up ? e + 9'h1 : e - 9'h1;
            if (e == 9'h006) up = 1'b0;
            if (e == 9'h001) up = 1'b1;
            scan();
            chk({fchg, radj, recal}, 24'h4);
            chk(idle, e);
        end
        host.wr(ADDR_MODE, 8'h00);
        host.wr(ADDR_IDLE0, 8'h00);
        rd(ADDR_IDLE0, 8'h00);
        chk(idle, 24'h100);
        scan();
        chk(fchg, 24'h0);
        host.wr(ADDR_IDLE0, 8'h02);
        host.wr(ADDR_IDLE1, 8'h07);
        host.wr(ADDR_IDLE2, 8'h09);
        host.wr(ADDR_NOISE, 8'h30);
        host.wr(ADDR_MODE, 8'h40);
        noise(3, 12'sd4);
        noise(3, -12'sd4);
        scan();
        no_hop(6);
        noise(3, 12'sd5);
        scan();
        no_hop(6);
        noise(2, 12'sd5);
        noise(2, -12'sd5);
        scan();
        noise(1, 12'sd5);
        noise(1, -12'sd5);
        scan();
        no_hop(6);
        calibrating = 1'b1;
        noise(3, 12'sd5);
        noise(3, -12'sd5);
        scan();
        no_hop(10);
        calibrating = 1'b0;
        wait_hop(9'h007, 2'b01, 8'h00);
        host.wr(ADDR_OFS_ONE, 8'h11);
        host.wr(ADDR_OFS_TWO, 8'h22);
        host.wr(ADDR_MODE, 8'h80);
        noise(3, -12'sd5);
        noise(3, 12'sd5);
        scan();
        wait_hop(9'h009, 2'b10, 8'h22);
        noise(3, 12'sd5);
        noise(3, -12'sd5);
        scan();
        wait_hop(9'h002, 2'b10, 8'h00);
        @(posedge clk);
        #1;
        delta = '{1'b1, 5'h05, 12'sh000, 1'b1};
        @(posedge clk);
        #1;
        delta.valid = 1'b0;
        cnt = 0;
        while (krecal[5] !== 1'b1 && cnt < 1100 * MS) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        chk(krecal, 24'h000020);
        chk(24'(cnt >= 950 * MS && cnt <= 1050 * MS), 24'h1);
        host.seal(1'b0);
        repeat (600) @(posedge clk);
        #1;
        chk(crc_err, 24'h0);
        host.seal(1'b1);
        repeat (600) @(posedge clk);
        #1;
        chk(crc_err, 24'h1);
        print_verdict();
    end
endmodule : burst_frequency_hop_control_tb
